//--- spr_core.sv
// word reversal, polarity, rate-match and status logic of the standard pcs
`timescale 1ns/10ps
module spr_core #(
    parameter int DW = spr_pkg::DW
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire spr_pkg::spr_bus_req_t bus_req,
    output logic [31:0]                bus_rdata,
    input  wire logic [DW-1:0]         tx_data,
    input  wire logic                  tx_polarity_invert,
    output logic [DW-1:0]              tx_ser_data,
    input  wire logic [DW-1:0]         rx_ser_data,
    input  wire logic                  rx_ser_valid,
    input  wire logic                  rx_polarity_invert,
    input  wire logic                  rx_bit_reverse_en,
    input  wire logic                  rx_byte_reverse_en,
    output logic [DW-1:0]              rx_data,
    output logic                       rx_data_valid,
    output logic                       rx_skip_deleted,
    output logic                       rx_skip_inserted,
    output logic                       rm_fifo_full,
    output logic                       rm_fifo_empty,
    input  wire logic                  rx_level_above,
    output logic                       signal_detect,
    input  wire spr_pkg::spr_pipe_ctl_t pipe_ctl,
    input  wire logic                  rx_idle_raw,
    output logic                       rx_elec_idle,
    output logic [1:0]                 pll_rate,
    input  wire logic                  rate_switch_request,
    output logic                       rate_switch_complete,
    output logic                       irq
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                     ctrl;
        logic [spr_pkg::SKIP_W-1:0]      skip_neg;
        logic [spr_pkg::SKIP_W-1:0]      skip_pos;
        logic [spr_pkg::IRQ_W-1:0]       irq_stat;
        logic [spr_pkg::IRQ_W-1:0]       irq_mask;
        logic [31:0]                     rdata;
        logic [DW-1:0]                   tx_q;
        logic [DW-1:0]                   rx_q;
        logic                            rx_v;
        logic [spr_pkg::FIFO_DEPTH-1:0][DW-1:0] mem;
        logic [spr_pkg::PTR_W-1:0]       wp;
        logic [spr_pkg::PTR_W-1:0]       rp;
        logic [spr_pkg::FILL_W-1:0]      fill;
        logic [DW-1:0]                   out_q;
        logic                            out_v;
        logic                            del_p;
        logic                            ins_p;
        logic [2:0]                      lvl_s;
        logic                            lvl;
        logic [2:0]                      idl_s;
        logic                            idl;
        logic [2:0]                      sw_s;
        logic                            sw_done;
        logic [1:0]                      rate;
    } spr_state_t;

    spr_state_t s;
    spr_state_t next_s;

    function automatic logic [DW-1:0] bit_rev(input logic [DW-1:0] d, input spr_pkg::spr_width_t w);
        logic [DW-1:0] r;
        r = '0;
        for (int i = 0; i < DW; i++) begin
            case (w)
                spr_pkg::SPR_W8:  if (i < 8)  r[i] = d[7-i];
                spr_pkg::SPR_W10: if (i < 10) r[i] = d[9-i];
                spr_pkg::SPR_W16: if (i < 16) r[i] = d[15-i];
                default:          r[i] = d[DW-1-i];
            endcase
        end
        return r;
    endfunction

    function automatic logic [DW-1:0] byte_rev(input logic [DW-1:0] d, input spr_pkg::spr_width_t w);
        logic [DW-1:0] r;
        r = d;
        case (w)
            spr_pkg::SPR_W16: r = {4'h0, d[7:0], d[15:8]};
            spr_pkg::SPR_W20: r = {d[9:0], d[19:10]};
            default:          r = d;
        endcase
        return r;
    endfunction

    function automatic logic [DW-1:0] wmask(input spr_pkg::spr_width_t w);
        case (w)
            spr_pkg::SPR_W8:  wmask = 20'h000FF;
            spr_pkg::SPR_W10: wmask = 20'h003FF;
            spr_pkg::SPR_W16: wmask = 20'h0FFFF;
            default:          wmask = 20'hFFFFF;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // datapath and registers
    // -----------------------------------------------------------------
    spr_pkg::spr_width_t   width;
    spr_pkg::spr_rm_mode_t rm_mode;
    spr_pkg::spr_g3_mode_t g3_mode;
    logic                  rm_on;
    logic                  rm_ppm0;
    logic [DW-1:0]         rx_w;
    logic [DW-1:0]         tx_w;
    logic                  is_skip;
    logic                  do_del;
    logic                  do_ins;
    logic                  wr_en;
    logic                  rd_en;
    logic [spr_pkg::IRQ_W-1:0] ev;
    logic [spr_pkg::IRQ_W-1:0] clr;

    assign width   = spr_pkg::spr_width_t'(s.ctrl[spr_pkg::C_WIDTH +: 2]);
    assign rm_mode = spr_pkg::spr_rm_mode_t'(s.ctrl[spr_pkg::C_RMMODE +: 3]);
    assign g3_mode = spr_pkg::spr_g3_mode_t'(s.ctrl[spr_pkg::C_G3MODE +: 2]);

    always_comb begin
        next_s = s;
        // RL17 width selection
        // RL6 tx bit order
        tx_w = tx_data & wmask(width);
        if (s.ctrl[spr_pkg::C_TXBIT]) begin
            tx_w = bit_rev(tx_w, width);
        end
        // RL7 tx sub-word swap
        if (s.ctrl[spr_pkg::C_TXBYTE]) begin
            tx_w = byte_rev(tx_w, width);
        end
        // RL8 RL18 tx inversion
        if (s.ctrl[spr_pkg::C_TXPOL] && tx_polarity_invert) begin
            tx_w = ~tx_w & wmask(width);
        end
        next_s.tx_q = tx_w;

        // RL12 RL18 rx inversion, then aligner-stage reversals
        rx_w = rx_ser_data & wmask(width);
        if (s.ctrl[spr_pkg::C_RXPOL] && rx_polarity_invert) begin
            rx_w = ~rx_w & wmask(width);
        end
        // RL9 rx bit order
        if (s.ctrl[spr_pkg::C_RXBIT] && rx_bit_reverse_en) begin
            rx_w = bit_rev(rx_w, width);
        end
        // RL10 RL11 swap before fifo, wide only
        if (s.ctrl[spr_pkg::C_RXBYTE] && rx_byte_reverse_en) begin
            rx_w = byte_rev(rx_w, width);
        end
        next_s.rx_q = rx_w;
        next_s.rx_v = rx_ser_valid;

        // RL1 RL5 mode decode
        rm_on = (rm_mode != spr_pkg::SPR_RM_OFF) &&
                !(s.ctrl[spr_pkg::C_GEN3] && g3_mode == spr_pkg::SPR_G3_BYPASS);
        rm_ppm0 = (rm_mode == spr_pkg::SPR_RM_PIPE0) ||
                  (s.ctrl[spr_pkg::C_GEN3] && g3_mode == spr_pkg::SPR_G3_0PPM);
        // RL2 RL3 skip recognition against both disparities
        is_skip = (s.rx_q == (s.skip_neg & wmask(width))) || (s.rx_q == (s.skip_pos & wmask(width)));
        // zero-ppm mode never adds or drops, so skips pass through untouched
        do_del = rm_on && !rm_ppm0 && s.rx_v && is_skip && (s.fill >= spr_pkg::FILL_HIGH);
        do_ins = rm_on && !rm_ppm0 && (s.fill <= spr_pkg::FILL_LOW) && (s.fill != '0) &&
                 is_skip && s.rx_v;
        wr_en = rm_on && s.rx_v && !do_del && (s.fill != spr_pkg::FILL_MAX);
        rd_en = rm_on && (s.fill >= spr_pkg::FILL_MID || (s.fill != '0 && !s.rx_v));
        next_s.del_p = do_del;
        next_s.ins_p = do_ins;
        if (wr_en) begin
            next_s.mem[s.wp] = s.rx_q;
            next_s.wp = s.wp + 1'b1;
        end
        // insertion repeats a skip by writing it twice
        if (do_ins && wr_en) begin
            next_s.mem[s.wp + 1'b1] = s.rx_q;
            next_s.wp = s.wp + 2'd2;
        end
        if (rd_en) begin
            next_s.out_q = s.mem[s.rp];
            next_s.rp = s.rp + 1'b1;
        end else if (!rm_on) begin
            next_s.out_q = s.rx_q;
        end
        next_s.out_v = rm_on ? rd_en : s.rx_v;
        next_s.fill = s.fill + (wr_en ? ((do_ins && s.fill != spr_pkg::FILL_MAX - 1) ? 4'h2 : 4'h1) : 4'h0)
                    - (rd_en ? 4'h1 : 4'h0);
        if (!rm_on) begin
            next_s.wp   = '0;
            next_s.rp   = '0;
            next_s.fill = '0;
        end

        // pin synchronisers, second and third stage compared
        next_s.lvl_s = {s.lvl_s[1:0], rx_level_above};
        next_s.idl_s = {s.idl_s[1:0], rx_idle_raw};
        next_s.sw_s  = {s.sw_s[1:0], rate_switch_request};
        if (s.lvl_s[2] == s.lvl_s[1]) next_s.lvl = s.lvl_s[2];
        if (s.idl_s[2] == s.idl_s[1]) next_s.idl = s.idl_s[2];
        // RL14 rate switch acknowledged once request seen steady
        next_s.sw_done = (s.sw_s[2] == s.sw_s[1]) && s.sw_s[2] && !s.sw_done;
        if (next_s.sw_done) next_s.rate = pipe_ctl.rate;

        // RL4 RL13 RL15 events set sticky bits, set wins over clear
        ev = '0;
        ev[spr_pkg::IRQ_FULL]   = s.ctrl[spr_pkg::C_FLAGEN] && s.fill == spr_pkg::FILL_MAX && rm_on;
        ev[spr_pkg::IRQ_EMPTY]  = s.ctrl[spr_pkg::C_FLAGEN] && s.fill == '0 && rm_on;
        ev[spr_pkg::IRQ_SIGDET] = s.ctrl[spr_pkg::C_SDEN] && !s.lvl && next_s.lvl;
        ev[spr_pkg::IRQ_IDLE]   = s.idl != next_s.idl;
        clr = '0;
        next_s.rdata = '0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                spr_pkg::A_CTRL:    next_s.ctrl     = bus_req.wdata[15:0];
                spr_pkg::A_SKIPNEG: next_s.skip_neg = bus_req.wdata[spr_pkg::SKIP_W-1:0];
                spr_pkg::A_SKIPPOS: next_s.skip_pos = bus_req.wdata[spr_pkg::SKIP_W-1:0];
                spr_pkg::A_IRQ:     clr = bus_req.wdata[spr_pkg::IRQ_W-1:0];
                spr_pkg::A_MASK:    next_s.irq_mask = bus_req.wdata[spr_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        next_s.irq_stat = (s.irq_stat & ~clr) | ev;
        if (bus_req.rd) begin
            case (bus_req.addr)
                spr_pkg::A_CTRL:    next_s.rdata = {16'h0000, s.ctrl};
                spr_pkg::A_SKIPNEG: next_s.rdata = {12'h000, s.skip_neg};
                spr_pkg::A_SKIPPOS: next_s.rdata = {12'h000, s.skip_pos};
                spr_pkg::A_STATUS:  next_s.rdata = {24'h000000, s.fill, s.idl, s.lvl,
                                                    s.fill == '0, s.fill == spr_pkg::FILL_MAX};
                spr_pkg::A_IRQ:     next_s.rdata = {28'h0000000, s.irq_stat};
                spr_pkg::A_MASK:    next_s.rdata = {28'h0000000, s.irq_mask};
                default:            next_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s          <= '0;
            s.ctrl     <= spr_pkg::CTRL_RST;
            s.skip_neg <= spr_pkg::SKIP_NEG_RST;
            s.skip_pos <= spr_pkg::SKIP_POS_RST;
        end else begin
            s <= next_s;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign bus_rdata            = s.rdata;
    assign tx_ser_data          = s.tx_q;
    assign rx_data              = s.out_q;
    assign rx_data_valid        = s.out_v;
    assign rx_skip_deleted      = s.del_p;
    assign rx_skip_inserted     = s.ins_p;
    // RL4 flags gated by enable
    assign rm_fifo_full         = s.ctrl[spr_pkg::C_FLAGEN] && s.fill == spr_pkg::FILL_MAX;
    assign rm_fifo_empty        = s.ctrl[spr_pkg::C_FLAGEN] && s.fill == '0;
    // RL13 gated detect
    assign signal_detect        = s.ctrl[spr_pkg::C_SDEN] && s.lvl;
    // RL15 idle status, inference select passes to infer gate
    assign rx_elec_idle         = s.idl && pipe_ctl.eidle_infer_sel == 1'b0 ? s.idl : s.idl && !s.lvl;
    assign pll_rate             = s.rate;
    assign rate_switch_complete = s.sw_done;
    assign irq                  = |(s.irq_stat & s.irq_mask);

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_tx_pol_inv: assert property ((s.ctrl[spr_pkg::C_TXPOL] && tx_polarity_invert && !s.ctrl[spr_pkg::C_TXBIT] && !s.ctrl[spr_pkg::C_TXBYTE]) |=> tx_ser_data == $past(~tx_data & wmask(width))) else $error("tx inversion wrong"); // RL8
    a_tx_pass: assert property ((s.ctrl[15:7] == '0 && $stable(s.ctrl)) |=> tx_ser_data == $past(tx_data & wmask(width))) else $error("tx passthrough wrong"); // RL18
    a_tx_byte_swap: assert property ((s.ctrl[spr_pkg::C_TXBYTE] && !s.ctrl[spr_pkg::C_TXBIT] && !s.ctrl[spr_pkg::C_TXPOL] && width == spr_pkg::SPR_W20) |=> tx_ser_data == {$past(tx_data[9:0]), $past(tx_data[19:10])}) else $error("tx swap wrong"); // RL7
    a_tx_bit_rev: assert property ((s.ctrl[spr_pkg::C_TXBIT] && !s.ctrl[spr_pkg::C_TXBYTE] && !s.ctrl[spr_pkg::C_TXPOL] && width == spr_pkg::SPR_W20) |=> tx_ser_data[0] == $past(tx_data[19])) else $error("tx bit order wrong"); // RL6
    a_rx_pol_inv: assert property ((s.ctrl[spr_pkg::C_RXPOL] && rx_polarity_invert && !s.ctrl[spr_pkg::C_RXBIT] && !s.ctrl[spr_pkg::C_RXBYTE]) |=> s.rx_q == $past(~rx_ser_data & wmask(width))) else $error("rx inversion wrong"); // RL12
    a_rx_bit_rev: assert property ((s.ctrl[spr_pkg::C_RXBIT] && rx_bit_reverse_en && !s.ctrl[spr_pkg::C_RXPOL] && !s.ctrl[spr_pkg::C_RXBYTE] && width == spr_pkg::SPR_W10) |=> s.rx_q[9] == $past(rx_ser_data[0])) else $error("rx bit order wrong"); // RL9
    a_rx_byte_narrow: assert property ((s.ctrl[spr_pkg::C_RXBYTE] && !s.ctrl[spr_pkg::C_RXBIT] && !s.ctrl[spr_pkg::C_RXPOL] && width == spr_pkg::SPR_W8) |=> s.rx_q == $past(rx_ser_data & wmask(width))) else $error("rx swap at narrow width"); // RL11
    a_rx_byte_swap: assert property ((s.ctrl[spr_pkg::C_RXBYTE] && rx_byte_reverse_en && !s.ctrl[spr_pkg::C_RXBIT] && !s.ctrl[spr_pkg::C_RXPOL] && width == spr_pkg::SPR_W16) |=> s.rx_q[15:8] == $past(rx_ser_data[7:0])) else $error("rx swap wrong"); // RL10
    a_flag_gate: assert property (!s.ctrl[spr_pkg::C_FLAGEN] |-> !rm_fifo_full && !rm_fifo_empty) else $error("flag without enable"); // RL4
    a_sigdet_gate: assert property (!s.ctrl[spr_pkg::C_SDEN] |-> !signal_detect) else $error("detect without enable"); // RL13
    a_skip_del: assert property (do_del |=> rx_skip_deleted && s.fill <= $past(s.fill)) else $error("deletion grew fifo"); // RL2
    a_zero_ppm: assert property (rm_ppm0 |=> !rx_skip_deleted && !rx_skip_inserted) else $error("zero ppm changed rate"); // RL5
    a_sw_done: assert property ($rose(s.sw_s[2]) && s.sw_s[1] |=> rate_switch_complete) else $error("switch not done"); // RL14

    c_del: cover property (rx_skip_deleted);
    c_ins: cover property (rx_skip_inserted);
    c_sw:  cover property (rate_switch_complete);
    c_irq: cover property (irq);

endmodule

//--- spr_pkg.sv
// constants, types and operation list for the standard pcs word handling block
// Operation
// RL1: rate-match modes: off, basic10, basic20, gbe, pipe, pipe0
// RL2: negative-disparity 20-bit skip pattern configurable
// RL3: separate positive-disparity 20-bit skip pattern
// RL4: optional rate-match full and empty flags
// RL5: gen3 rate-match: bypass, 0 ppm, 600 ppm
// RL6: tx bit reversal sends msb first
// RL7: tx byte reversal swaps sub-words at 16/20
// RL8: tx polarity input inverts tx data
// RL9: rx bit reversal under control input
// RL10: rx byte reversal swaps sub-words under control
// RL11: rx byte swap before fifo, 16/20 only
// RL12: rx polarity input inverts rx data
// RL13: signal detect output above threshold
// RL14: rate select, switch and done ports
// RL15: electrical-idle infer select and idle status
// RL16: surrounding logic wires pipe clocks to pll
// RL17: pcs to serializer width 8/10/16/20
// RL18: polarity inverts all bits, one register stage
package spr_pkg;

    localparam int DW          = 20;
    localparam int SKIP_W      = 20;
    localparam int FIFO_DEPTH  = 8;
    localparam int PTR_W       = 3;
    localparam int FILL_W      = 4;
    localparam logic [3:0] FILL_HIGH = 4'h6;
    localparam logic [3:0] FILL_LOW  = 4'h2;
    localparam logic [3:0] FILL_MID  = 4'h4;
    localparam logic [3:0] FILL_MAX  = 4'h8;

    localparam logic [SKIP_W-1:0] SKIP_NEG_RST = 20'h00000;
    localparam logic [SKIP_W-1:0] SKIP_POS_RST = 20'h00000;

    localparam int IRQ_W      = 4;
    localparam int IRQ_FULL   = 0;
    localparam int IRQ_EMPTY  = 1;
    localparam int IRQ_SIGDET = 2;
    localparam int IRQ_IDLE   = 3;

    // register offsets
    localparam logic [3:0] A_CTRL    = 4'h0;
    localparam logic [3:0] A_SKIPNEG = 4'h1;
    localparam logic [3:0] A_SKIPPOS = 4'h2;
    localparam logic [3:0] A_STATUS  = 4'h3;
    localparam logic [3:0] A_IRQ     = 4'h4;
    localparam logic [3:0] A_MASK    = 4'h5;

    // ctrl field positions
    localparam int C_WIDTH   = 0;
    localparam int C_RMMODE  = 2;
    localparam int C_G3MODE  = 5;
    localparam int C_TXBIT   = 7;
    localparam int C_TXBYTE  = 8;
    localparam int C_TXPOL   = 9;
    localparam int C_RXBIT   = 10;
    localparam int C_RXBYTE  = 11;
    localparam int C_RXPOL   = 12;
    localparam int C_FLAGEN  = 13;
    localparam int C_SDEN    = 14;
    localparam int C_GEN3    = 15;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    typedef enum logic [1:0] {
        SPR_W8  = 2'b00,
        SPR_W10 = 2'b01,
        SPR_W16 = 2'b10,
        SPR_W20 = 2'b11
    } spr_width_t;

    typedef enum logic [2:0] {
        SPR_RM_OFF    = 3'b000,
        SPR_RM_BASIC10 = 3'b001,
        SPR_RM_BASIC20 = 3'b010,
        SPR_RM_GBE    = 3'b011,
        SPR_RM_PIPE   = 3'b100,
        SPR_RM_PIPE0  = 3'b101
    } spr_rm_mode_t;

    typedef enum logic [1:0] {
        SPR_G3_BYPASS = 2'b00,
        SPR_G3_0PPM   = 2'b01,
        SPR_G3_600PPM = 2'b10
    } spr_g3_mode_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } spr_bus_req_t;

    typedef struct packed {
        logic [1:0] rate;
        logic       eidle_infer_sel;
    } spr_pipe_ctl_t;

endpackage

//--- spr_serdes_model.sv
// far-end model: deserializer word source and receive level sensor
`timescale 1ns/10ps
module spr_serdes_model (
    input  wire logic        ref_clk,
    input  wire logic        send,
    input  wire logic [19:0] word,
    input  wire logic        level_on,
    output logic [19:0]      rx_ser_data,
    output logic             rx_ser_valid,
    output logic             rx_level_above,
    output logic             rx_idle_raw
);
    initial rx_ser_data = 20'h5A5A5;
    initial rx_ser_valid = 1'b0;
    always @(posedge ref_clk) begin
        rx_ser_valid <= send;
        // an idle lane must not look like a held word, so it toggles every cycle
        rx_ser_data  <= send ? word : ~rx_ser_data;
    end
    assign rx_level_above = level_on;
    assign rx_idle_raw    = ~level_on;
endmodule

//--- std_pcs_reversal_polarity_ratematch_bench.sv
// self-checking bench for the standard pcs word handling block
`timescale 1ns/10ps
module std_pcs_reversal_polarity_ratematch_bench;
    logic                  ref_clk, rst_n;
    spr_pkg::spr_bus_req_t bus_req;
    spr_pkg::spr_pipe_ctl_t pipe_ctl;
    logic [31:0]           bus_rdata, rd_val;
    logic [19:0]           tx_data, tx_ser_data, rx_ser_data, rx_data, fe_word;
    logic                  tx_polarity_invert, rx_ser_valid, rx_polarity_invert;
    logic                  rx_bit_reverse_en, rx_byte_reverse_en, rx_data_valid;
    logic                  rx_skip_deleted, rx_skip_inserted, rm_fifo_full, rm_fifo_empty;
    logic                  rx_level_above, signal_detect, rx_idle_raw, rx_elec_idle;
    logic [1:0]            pll_rate;
    logic                  rate_switch_request, rate_switch_complete, irq, fe_send, fe_level;
    int                    n_mismatch = 0;
    int                    n_checks   = 0;

    spr_core spr_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .tx_data(tx_data), .tx_polarity_invert(tx_polarity_invert), .tx_ser_data(tx_ser_data),
        .rx_ser_data(rx_ser_data), .rx_ser_valid(rx_ser_valid), .rx_polarity_invert(rx_polarity_invert),
        .rx_bit_reverse_en(rx_bit_reverse_en), .rx_byte_reverse_en(rx_byte_reverse_en), .rx_data(rx_data),
        .rx_data_valid(rx_data_valid), .rx_skip_deleted(rx_skip_deleted), .rx_skip_inserted(rx_skip_inserted),
        .rm_fifo_full(rm_fifo_full), .rm_fifo_empty(rm_fifo_empty), .rx_level_above(rx_level_above),
        .signal_detect(signal_detect), .pipe_ctl(pipe_ctl), .rx_idle_raw(rx_idle_raw),
        .rx_elec_idle(rx_elec_idle), .pll_rate(pll_rate), .rate_switch_request(rate_switch_request),
        .rate_switch_complete(rate_switch_complete), .irq(irq));

    spr_serdes_model spr_serdes_model_i (.ref_clk(ref_clk), .send(fe_send), .word(fe_word),
        .level_on(fe_level), .rx_ser_data(rx_ser_data), .rx_ser_valid(rx_ser_valid),
        .rx_level_above(rx_level_above), .rx_idle_raw(rx_idle_raw));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // a gap cycle after each strobe keeps one assignment per signal per step
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr    <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd   <= 1'b0;
        #1 d = bus_rdata;
        @(posedge ref_clk);
    endtask

    // reference word path: bit order, then half swap, then complement
    function automatic logic [19:0] ref_word(input logic [19:0] w, input int n, input logic [2:0] f);
        logic [19:0] r;
        r = w;
        if (f[0]) for (int i = 0; i < n; i++) r[i] = w[n-1-i];
        if (f[1] && n == 16) r = {4'h0, r[7:0], r[15:8]};
        if (f[1] && n == 20) r = {r[9:0], r[19:10]};
        if (f[2]) r = ~r;
        return r & 20'((64'h1 << n) - 64'h1);
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        bus_rd(spr_pkg::A_CTRL, rd_val);
        check("ctrl reset", rd_val, 32'h0000_0000);
        bus_wr(spr_pkg::A_SKIPNEG, 32'h000A_BCDE);
        bus_wr(spr_pkg::A_SKIPPOS, 32'h0001_2345);
        bus_rd(spr_pkg::A_SKIPNEG, rd_val);
        check("skip neg", rd_val, 32'h000A_BCDE);
        bus_rd(spr_pkg::A_SKIPPOS, rd_val);
        check("skip pos", rd_val, 32'h0001_2345);
        bus_rd(4'hF, rd_val);
        check("unmapped", rd_val, 32'h0000_0000);
    endtask

    // both directions share one table of width, order flags and polarity pin
    task automatic t_words();
        int          wn  [7] = '{20, 20, 16, 20, 20, 10, 8};
        logic [2:0]  fl  [7] = '{3'h1, 3'h2, 3'h2, 3'h7, 3'h4, 3'h1, 3'h2};
        logic        pin [7] = '{0, 0, 0, 1, 0, 0, 0};
        logic [1:0]  wc;
        for (int i = 0; i < 7; i++) begin
            wc = wn[i] == 8 ? 2'h0 : wn[i] == 10 ? 2'h1 : wn[i] == 16 ? 2'h2 : 2'h3;
            bus_wr(spr_pkg::A_CTRL, {16'h0, 16'(fl[i]) << spr_pkg::C_TXBIT | 16'(fl[i]) << spr_pkg::C_RXBIT
                   | 16'(wc)});
            tx_data            <= 20'h3C5A1 ^ 20'(i);
            fe_word            <= 20'h81E47 ^ 20'(i);
            fe_send            <= 1'b1;
            tx_polarity_invert <= pin[i];
            rx_polarity_invert <= pin[i];
            rx_bit_reverse_en  <= fl[i][0];
            rx_byte_reverse_en <= fl[i][1];
            repeat (5) @(posedge ref_clk);
            #1;
            check("tx word", tx_ser_data, ref_word(20'h3C5A1 ^ 20'(i), wn[i],
                  {fl[i][2] & pin[i], fl[i][1:0]}));
            check("rx word", rx_data, ref_word(20'h81E47 ^ 20'(i), wn[i],
                  {fl[i][2] & pin[i], fl[i][1:0]}));
            check("rx valid", rx_data_valid, 1);
            @(posedge ref_clk);
        end
        fe_send <= 1'b0;
    endtask

    // a skip right behind the first word meets a shallow fifo and is written twice in the basic20 runs, once in pipe0
    task automatic t_ratematch();
        logic [19:0]           pat [3] = '{20'hABCDE, 20'h12345, 20'hABCDE};
        spr_pkg::spr_rm_mode_t md  [3] = '{spr_pkg::SPR_RM_BASIC20, spr_pkg::SPR_RM_BASIC20, spr_pkg::SPR_RM_PIPE0};
        int                    ins [3] = '{1, 1, 0};
        int                    seen;
        for (int j = 0; j < 3; j++) begin
            bus_wr(spr_pkg::A_CTRL, 32'h0000_0003 | 32'(md[j]) << spr_pkg::C_RMMODE);
            fe_word <= 20'h11111;
            fe_send <= 1'b1;
            @(posedge ref_clk);
            fe_word <= pat[j];
            seen = 0;
            repeat (8) begin
                @(posedge ref_clk);
                #1;
                if (rx_skip_inserted === 1'b1) seen++;
            end
            check("skip inserted", seen, ins[j]);
            check("rm word", rx_data, pat[j]);
            @(posedge ref_clk);
            fe_send <= 1'b0;
            bus_wr(spr_pkg::A_CTRL, 32'h0000_0003);
        end
    endtask

    task automatic t_flags();
        bus_wr(spr_pkg::A_CTRL, 32'h0000_2003 | 32'(spr_pkg::SPR_RM_BASIC20) << spr_pkg::C_RMMODE);
        repeat (12) @(posedge ref_clk);
        #1;
        check("fifo empty", rm_fifo_empty, 1);
        check("fifo full", rm_fifo_full, 0);
        @(posedge ref_clk);
    endtask

    task automatic t_irq();
        bus_wr(spr_pkg::A_CTRL, 32'h0000_4000);
        bus_wr(spr_pkg::A_MASK, 32'h0);
        bus_wr(spr_pkg::A_IRQ, 32'hF);
        fe_level <= 1'b1;
        for (int k = 0; k < 12 && signal_detect !== 1'b1; k++) @(posedge ref_clk);
        check("signal detect", signal_detect, 1);
        bus_rd(spr_pkg::A_IRQ, rd_val);
        check("detect event", rd_val & 32'h4, 32'h4);
        check("irq masked", irq, 0);
        bus_wr(spr_pkg::A_MASK, 32'h4);
        check("irq unmasked", irq, 1);
        bus_wr(spr_pkg::A_IRQ, 32'h4);
        check("irq cleared", irq, 0);
    endtask

    task automatic t_pipe();
        fe_level <= 1'b0;
        for (int k = 0; k < 12 && rx_elec_idle !== 1'b1; k++) @(posedge ref_clk);
        check("elec idle", rx_elec_idle, 1);
        pipe_ctl.rate       <= 2'h2;
        rate_switch_request <= 1'b1;
        for (int k = 0; k < 20 && rate_switch_complete !== 1'b1; k++) @(posedge ref_clk);
        check("switch done", rate_switch_complete, 1);
        repeat (2) @(posedge ref_clk);
        check("pll rate", pll_rate, 2);
        rate_switch_request <= 1'b0;
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    // the one bench clock stands in for the pll's pipe clocks
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        pipe_ctl = '0;
        {tx_data, fe_word} = '0;
        {tx_polarity_invert, rx_polarity_invert, rx_bit_reverse_en, rx_byte_reverse_en} = '0;
        {fe_send, fe_level, rate_switch_request} = '0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_words();
        t_ratematch();
        t_flags();
        t_irq();
        t_pipe();
        tally_and_finish();
    end

    initial begin
        #(4 * 5000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
